/* File: core/iibs_seq.v */
// i/o instruction bus sequencer with ahb-lite register slave
`timescale 1ns/1ps
// Operation
// - six i/o instructions: acc in/out, mem in/out, unit command, unit test
// - acc in/out move data between accumulator a and the unit
// - mem in/out move data between memory and unit, bypassing a
// - acc in/out decoded from one memory word
// - mem in/out, command and test fetch two consecutive words
// - command instruction also starts channels and special units
// - connect named unit, transfer, then disconnect it
// - unit data passes through two synchroniser flops to processor, mem in also holds it in in_r
// - i/o path busy only while an i/o instruction runs
// - wait mode holds transfer until unit raises ready
// - wait mode samples ready each machine cycle, transfers next cycle
// - after wait transfer disconnect and continue without skip
// - skip mode samples ready exactly once
// - skip mode ready: transfer and advance program counter by instruction length plus one
// - skip mode not ready: disconnect, no transfer, advance by instruction length
// - test always sends word, then test return decides the skip
// - indirect flag 1 makes second word an address, else immediate
// - immediate mode sends second word for mem out, command, test
// - immediate mem in stores received data into second word location
// - address mode applies indexing and repeated indirection
// - each machine cycle has sixteen timing steps
`include "iibs_defs.vh"
module iibs_seq #(
	parameter AW = 8
) (
	input wire clk,
	input wire nrst,
	input wire hsel,
	input wire [AW-1:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	output wire [14:0] mem_addr,
	output wire mem_rd,
	output wire mem_wr,
	output wire [15:0] mem_wdata,
	input wire [15:0] mem_rdata,
	output wire io_connect,
	output wire [5:0] io_unit,
	output wire [15:0] io_out_data,
	output wire io_out_strobe,
	output wire io_in_strobe,
	input wire [15:0] io_in_data,
	input wire io_ready,
	input wire io_test_return
);
// ---------------------------------------------
// states
// ---------------------------------------------
localparam S_IDLE = 7'b0000001;
localparam S_FET1 = 7'b0000010;
localparam S_FET2 = 7'b0000100;
localparam S_IND = 7'b0001000;
localparam S_CONN = 7'b0010000;
localparam S_XFER = 7'b0100000;
localparam S_DONE = 7'b1000000;
// ---------------------------------------------
// declarations
// ---------------------------------------------
reg [6:0] state_r;
reg [6:0] state_nxt;
reg [3:0] tcnt_r;
reg [14:0] pc_r;
reg [15:0] acca_r;
reg [15:0] idxb_r;
reg [15:0] w1_r;
reg [15:0] cur_r;
reg [14:0] opaddr_r;
reg chain_r;
reg skip_r;
reg done_r;
reg [15:0] out_r;
reg [15:0] in_r;
reg ready_s1_r;
reg ready_s2_r;
reg test_s1_r;
reg test_s2_r;
reg [15:0] din_s1_r;
reg [15:0] din_s2_r;
reg wr_pend_r;
reg [AW-1:0] waddr_r;
reg [31:0] hrdata_r;
wire t_last;
wire t_first;
wire t_capt;
wire [3:0] op;
wire two_word;
wire is_out;
wire is_test;
wire wait_mode;
wire go;
wire busy;
wire addr_ok;
wire [14:0] ea;
// ---------------------------------------------
// functions
// ---------------------------------------------
// effective address of an address word
function [14:0] eff_addr;
	input [15:0] word;
	input map;
	input [14:0] pc;
	input [15:0] idx;
	reg [14:0] base;
	begin
		base = {(map ? pc[14] : 1'b0), word[`IIBS_W2_ADDR]};
		if (word[`IIBS_W2_IDX]) begin
			eff_addr = base + idx[14:0];
		end else begin
			eff_addr = base;
		end
	end
endfunction
// register read mux
function [31:0] reg_read;
	input [AW-1:0] a;
	input [6:0] st;
	input sk;
	input dn;
	input [14:0] pc;
	input [15:0] ra;
	input [15:0] rb;
	begin
		reg_read = 32'h0000_0000;
		case (a)
		`IIBS_OFF_STAT: begin
			reg_read[`IIBS_STAT_BUSY] = (st != S_IDLE);
			reg_read[`IIBS_STAT_SKIP] = sk;
			reg_read[`IIBS_STAT_WAIT] = (st == S_CONN);
			reg_read[`IIBS_STAT_DONE] = dn;
		end
		`IIBS_OFF_PC: begin
			reg_read[14:0] = pc;
		end
		`IIBS_OFF_ACCA: begin
			reg_read[15:0] = ra;
		end
		`IIBS_OFF_IDXB: begin
			reg_read[15:0] = rb;
		end
		default: begin
			reg_read = 32'h0000_0000;
		end
		endcase
	end
endfunction
// ---------------------------------------------
// decode
// ---------------------------------------------
assign t_last = (tcnt_r == `IIBS_T_LAST);
assign t_first = (tcnt_r == `IIBS_T_FIRST);
assign t_capt = (tcnt_r == `IIBS_T_CAPT);
assign op = w1_r[`IIBS_W1_OP];
assign two_word = (op != `IIBS_OP_ACC_IN) && (op != `IIBS_OP_ACC_OUT);
assign is_test = (op == `IIBS_OP_TEST);
assign is_out = (op == `IIBS_OP_ACC_OUT) || (op == `IIBS_OP_MEM_OUT) || (op == `IIBS_OP_CMD) || is_test;
assign wait_mode = w1_r[`IIBS_W1_WAIT];
assign busy = (state_r != S_IDLE);
assign ea = eff_addr(cur_r, w1_r[`IIBS_W1_MAP], pc_r, idxb_r);
assign addr_ok = hsel && hready && htrans[1];
assign go = wr_pend_r && (waddr_r == `IIBS_OFF_CTRL) && hwdata[`IIBS_CTRL_GO] && !busy;
// ---------------------------------------------
// bus outputs
// ---------------------------------------------
assign hrdata = hrdata_r;
assign hreadyout = 1'b1;
assign hresp = 1'b0;
// ---------------------------------------------
// memory and i/o bus outputs
// ---------------------------------------------
assign mem_rd = t_first && ((state_r == S_FET1) || (state_r == S_FET2) || (state_r == S_IND && cur_r[`IIBS_W2_IND])
	|| (state_r == S_CONN && is_out && op != `IIBS_OP_ACC_OUT));
assign mem_addr = (state_r == S_FET1) ? pc_r :
	(state_r == S_FET2) ? pc_r + 15'h0001 :
	(state_r == S_IND) ? ea : opaddr_r;
assign mem_wr = (state_r == S_XFER) && t_last && (op == `IIBS_OP_MEM_IN);
assign mem_wdata = in_r;
assign io_connect = (state_r == S_CONN) || (state_r == S_XFER);
assign io_unit = w1_r[`IIBS_W1_UNIT];
assign io_out_data = out_r;
assign io_out_strobe = (state_r == S_XFER) && (tcnt_r == `IIBS_T_STROBE) && is_out;
assign io_in_strobe = (state_r == S_XFER) && (tcnt_r == `IIBS_T_STROBE) && !is_out;
// ---------------------------------------------
// input synchronisers
// ---------------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		ready_s1_r <= 1'b0;
		ready_s2_r <= 1'b0;
		test_s1_r <= 1'b0;
		test_s2_r <= 1'b0;
		din_s1_r <= `IIBS_RST_WORD;
		din_s2_r <= `IIBS_RST_WORD;
	end else begin
		ready_s1_r <= io_ready;
		ready_s2_r <= ready_s1_r;
		test_s1_r <= io_test_return;
		test_s2_r <= test_s1_r;
		din_s1_r <= io_in_data;
		din_s2_r <= din_s1_r;
	end
end
// ---------------------------------------------
// next state
// ---------------------------------------------
always @* begin
	state_nxt = state_r;
	case (state_r)
	S_IDLE: begin
		if (go) begin
			state_nxt = S_FET1;
		end
	end
	S_FET1: begin
		if (t_last) begin
			state_nxt = two_word ? S_FET2 : S_CONN;
		end
	end
	S_FET2: begin
		if (t_last) begin
			state_nxt = w1_r[`IIBS_W1_IND] ? S_IND : S_CONN;
		end
	end
	S_IND: begin
		if (t_last && !chain_r) begin
			state_nxt = S_CONN;
		end
	end
	S_CONN: begin
		if (t_last) begin
			if (is_test || ready_s2_r) begin
				state_nxt = S_XFER;
			end else if (!wait_mode) begin
				state_nxt = S_DONE;
			end else begin
				state_nxt = S_CONN;
			end
		end
	end
	S_XFER: begin
		if (t_last) begin
			state_nxt = S_DONE;
		end
	end
	S_DONE: begin
		if (t_last) begin
			state_nxt = S_IDLE;
		end
	end
	default: begin
		state_nxt = S_IDLE;
	end
	endcase
end
// ---------------------------------------------
// sequencer
// ---------------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		state_r <= S_IDLE;
		tcnt_r <= `IIBS_T_FIRST;
		w1_r <= `IIBS_RST_WORD;
		cur_r <= `IIBS_RST_WORD;
		opaddr_r <= `IIBS_RST_PC;
		chain_r <= 1'b0;
		skip_r <= 1'b0;
		done_r <= 1'b0;
		out_r <= `IIBS_RST_WORD;
		in_r <= `IIBS_RST_WORD;
	end else begin
		state_r <= state_nxt;
		if (state_r == S_IDLE) begin
			tcnt_r <= `IIBS_T_FIRST;
		end else begin
			tcnt_r <= tcnt_r + 4'h1;
		end
		if (go) begin
			skip_r <= 1'b0;
			done_r <= 1'b0;
		end
		if (state_r == S_FET1 && t_capt) begin
			w1_r <= mem_rdata;
		end
		if (state_r == S_FET2 && t_capt) begin
			cur_r <= mem_rdata;
			opaddr_r <= pc_r + 15'h0001;
		end
		if (state_r == S_IND) begin
			if (t_first) begin
				chain_r <= cur_r[`IIBS_W2_IND];
			end
			if (t_capt && chain_r) begin
				cur_r <= mem_rdata;
			end
			if (t_last && !chain_r) begin
				opaddr_r <= ea;
			end
		end
		if (state_r == S_CONN && t_capt) begin
			out_r <= (op == `IIBS_OP_ACC_OUT) ? acca_r : mem_rdata;
		end
		if (state_r == S_CONN && t_last) begin
			if (is_test) begin
				skip_r <= 1'b0;
			end else if (ready_s2_r) begin
				skip_r <= !wait_mode;
			end else if (!wait_mode) begin
				skip_r <= 1'b0;
			end
		end
		// unit word held from the strobe step so the memory store at step 15 sees it
		if (state_r == S_XFER && tcnt_r == `IIBS_T_STROBE) begin
			in_r <= din_s2_r;
		end
		if (state_r == S_XFER && t_last) begin
			if (is_test) begin
				skip_r <= test_s2_r;
			end
		end
		if (state_r == S_DONE && t_last) begin
			done_r <= 1'b1;
		end
	end
end
// ---------------------------------------------
// program counter and accumulators
// ---------------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		pc_r <= `IIBS_RST_PC;
		acca_r <= `IIBS_RST_WORD;
		idxb_r <= `IIBS_RST_WORD;
	end else begin
		if (state_r == S_DONE && t_last) begin
			pc_r <= pc_r + (two_word ? 15'h0002 : 15'h0001) + (skip_r ? 15'h0002 : 15'h0001) - 15'h0001;
		end else if (wr_pend_r && !busy && waddr_r == `IIBS_OFF_PC) begin
			pc_r <= hwdata[14:0];
		end
		if (state_r == S_XFER && t_last && op == `IIBS_OP_ACC_IN) begin
			acca_r <= din_s2_r;
		end else if (wr_pend_r && !busy && waddr_r == `IIBS_OFF_ACCA) begin
			acca_r <= hwdata[15:0];
		end
		if (wr_pend_r && !busy && waddr_r == `IIBS_OFF_IDXB) begin
			idxb_r <= hwdata[15:0];
		end
	end
end
// ---------------------------------------------
// ahb-lite slave
// ---------------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		wr_pend_r <= 1'b0;
		waddr_r <= {AW{1'b0}};
		hrdata_r <= 32'h0000_0000;
	end else begin
		wr_pend_r <= addr_ok && hwrite;
		if (addr_ok) begin
			waddr_r <= haddr;
		end
		if (addr_ok && !hwrite) begin
			hrdata_r <= reg_read(haddr, state_r, skip_r, done_r, pc_r, acca_r, idxb_r);
		end
	end
end
endmodule // iibs_seq

/* File: dv/iibs_seq_sva.sv */
// assertion checker for the i/o instruction bus sequencer
`timescale 1ns/1ps
module iibs_seq_chk (
	input wire clk,
	input wire nrst,
	input wire hreadyout,
	input wire hresp,
	input wire mem_rd,
	input wire mem_wr,
	input wire io_connect,
	input wire io_out_strobe,
	input wire io_in_strobe
);
	// --------
	// properties
	// --------
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	out_conn_a: assert property (io_out_strobe |-> io_connect && $past(io_connect, 24))
		else $error("output strobe without prior connect");
	in_conn_a: assert property (io_in_strobe |-> io_connect && $past(io_connect, 24))
		else $error("input strobe without prior connect");
	strobe_excl_a: assert property (!(io_out_strobe && io_in_strobe))
		else $error("both strobes at once");
	out_pulse_a: assert property (io_out_strobe |=> !io_out_strobe [*8])
		else $error("output strobe repeats too soon");
	rd_pulse_a: assert property (mem_rd |=> !mem_rd [*8])
		else $error("memory read repeats too soon");
	mem_store_a: assert property (mem_wr |-> io_connect && $past(io_in_strobe, 7))
		else $error("memory write not after input strobe");
	conn_hold_a: assert property ($rose(io_connect) |=> io_connect [*8])
		else $error("connect shorter than a cycle");
	disc_hold_a: assert property ($fell(io_connect) |=> !io_connect [*8])
		else $error("reconnect without done cycle");
	cover property (io_in_strobe);
	cover property (mem_wr);
	cover property ($fell(io_connect) && !$past(io_out_strobe, 8));
endmodule // iibs_seq_chk

bind iibs_seq iibs_seq_chk iibs_seq_chk_inst (.clk(clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
	.mem_rd(mem_rd), .mem_wr(mem_wr), .io_connect(io_connect), .io_out_strobe(io_out_strobe),
	.io_in_strobe(io_in_strobe));

/* File: dv/iibs_tb.sv */
// self-checking bench for the i/o instruction bus sequencer
`timescale 1ns/1ps
`include "iibs_defs.vh"
module io_instruction_bus_sequencer_tb_top;
	reg clk = 1'b0;
	reg nrst = 1'b0;
	reg hsel = 1'b0;
	reg [7:0] haddr = 8'h00;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0000_0000;
	reg rdy_en = 1'b0;
	reg tret = 1'b0;
	reg [15:0] in_word = 16'h0000;
	reg [15:0] mem_rdata = 16'h0000;
	reg [15:0] mem [0:63];
	reg [31:0] rd;
	integer fails = 0;
	integer n_compared = 0;
	integer t;
	wire [31:0] hrdata;
	wire hready;
	wire [14:0] mem_addr;
	wire mem_rd;
	wire mem_wr;
	wire [15:0] mem_wdata;
	wire io_connect;
	wire [5:0] io_unit;
	wire [15:0] io_out_data;
	wire io_out_strobe;
	wire io_in_strobe;
	wire [15:0] io_in_data;
	wire io_ready;
	wire io_test_return;
	wire [15:0] got;
	wire [7:0] n_out;
	always #10 clk = ~clk;
	iibs_seq iibs_seq_inst (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.io_connect(io_connect), .io_unit(io_unit), .io_out_data(io_out_data), .io_out_strobe(io_out_strobe),
		.io_in_strobe(io_in_strobe), .io_in_data(io_in_data), .io_ready(io_ready),
		.io_test_return(io_test_return));
	iibs_unit_model iibs_unit_model_inst (.clk(clk), .io_connect(io_connect), .io_unit(io_unit),
		.io_out_data(io_out_data), .io_out_strobe(io_out_strobe), .io_in_data(io_in_data), .io_ready(io_ready),
		.io_test_return(io_test_return), .rdy_en(rdy_en), .tret(tret), .in_word(in_word), .got(got),
		.n_out(n_out));
	// --------
	// memory with one cycle read latency
	// --------
	always @(posedge clk) begin
		if (mem_rd)
			mem_rdata <= mem[mem_addr[5:0]];
		if (mem_wr)
			mem[mem_addr[5:0]] <= mem_wdata;
	end
	// --------
	// tasks
	// --------
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				$display("wrong value %s exp %h seen %h", nm, exp, seen);
				fails = fails + 1;
			end
		end
	endtask
	task end_of_test;
		begin
			$display("compared %0d fails %0d", n_compared, fails);
			if (fails == 0 && n_compared > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task wt;
		integer i;
		begin
			i = 0;
			@(posedge clk);
			while (hready !== 1'b1 && i < 20) begin
				@(posedge clk);
				i = i + 1;
			end
			if (i >= 20) begin
				fails = fails + 1;
				end_of_test;
			end
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			hsel <= 1'b1;
			htrans <= 2'h2;
			haddr <= a;
			hwrite <= w;
			wt;
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			wt;
			rd = hrdata;
		end
	endtask
	task go(input [15:0] w1, input [15:0] w2);
		begin
			mem[16] = w1;
			mem[17] = w2;
			bus(1'b1, `IIBS_OFF_PC, 32'h0000_0010);
			bus(1'b1, `IIBS_OFF_CTRL, 32'h0000_0001);
		end
	endtask
	task fin(input [31:0] inc);
		integer i;
		begin
			i = 0;
			rd = 32'h0000_0001;
			while (rd[0] !== 1'b0 && i < 300) begin
				bus(1'b0, `IIBS_OFF_STAT, 32'h0000_0000);
				i = i + 1;
			end
			if (i >= 300) begin
				fails = fails + 1;
				end_of_test;
			end
			bus(1'b0, `IIBS_OFF_PC, 32'h0000_0000);
			chk("pc", rd, 32'h0000_0010 + inc);
		end
	endtask
	// --------
	// scenarios
	// --------
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		bus(1'b0, `IIBS_OFF_PC, 32'h0000_0000);
		chk("pc reset", rd, 32'h0000_0000);
		bus(1'b1, `IIBS_OFF_ACCA, 32'h0000_1234);
		rdy_en <= 1'b1;
		go(16'h2005, 16'h0000);
		fin(2);
		chk("acc out", got, 16'h1234);
		rdy_en <= 1'b0;
		go(16'h2005, 16'h0000);
		fin(1);
		chk("no transfer", n_out, 8'h01);
		rdy_en <= 1'b1;
		in_word <= 16'habcd;
		go(16'h1005, 16'h0000);
		fin(2);
		bus(1'b0, `IIBS_OFF_ACCA, 32'h0000_0000);
		chk("acc in", rd, 32'h0000_abcd);
		go(16'h4005, 16'h5a5a);
		fin(3);
		chk("mem out imm", got, 16'h5a5a);
		in_word <= 16'h0f0f;
		go(16'h3005, 16'h0000);
		fin(3);
		chk("mem in imm", mem[17], 16'h0f0f);
		bus(1'b1, `IIBS_OFF_IDXB, 32'h0000_0002);
		mem[34] = 16'hc3c3;
		go(16'h4805, 16'h8020);
		fin(3);
		chk("mem out addr", got, 16'hc3c3);
		mem[35] = 16'h3c3c;
		mem[40] = 16'h8021;
		go(16'h4805, 16'h4028);
		fin(3);
		chk("chained addr", got, 16'h3c3c);
		rdy_en <= 1'b0;
		go(16'h5205, 16'h7777);
		repeat (100) @(posedge clk);
		chk("held", n_out, 8'h04);
		bus(1'b0, `IIBS_OFF_STAT, 32'h0000_0000);
		chk("wait flag", rd[2], 1'b1);
		rdy_en <= 1'b1;
		fin(2);
		chk("command", got, 16'h7777);
		rdy_en <= 1'b0;
		for (t = 0; t < 2; t = t + 1) begin
			tret <= t[0];
			go(16'h6005, 16'h0100 + t[15:0]);
			fin(2 + t);
			chk("test word", got, 16'h0100 + t[15:0]);
		end
		end_of_test;
	end
endmodule // io_instruction_bus_sequencer_tb_top

/* File: dv/iibs_unit_model.sv */
// peripheral unit model on the i/o bus
`timescale 1ns/1ps
module iibs_unit_model #(
	parameter UNIT = 6'h05
) (
	input wire clk,
	input wire io_connect,
	input wire [5:0] io_unit,
	input wire [15:0] io_out_data,
	input wire io_out_strobe,
	output wire [15:0] io_in_data,
	output wire io_ready,
	output wire io_test_return,
	input wire rdy_en,
	input wire tret,
	input wire [15:0] in_word,
	output reg [15:0] got,
	output reg [7:0] n_out
);
	wire sel = io_connect && io_unit == UNIT;
	assign io_ready = sel && rdy_en;
	assign io_test_return = sel && tret;
	assign io_in_data = sel ? in_word : ~in_word;
	initial begin
		got = 16'h0000;
		n_out = 8'h00;
	end
	always @(posedge clk) begin
		if (io_out_strobe && sel) begin
			got <= io_out_data;
			n_out <= n_out + 8'h01;
		end
	end
endmodule // iibs_unit_model

/* File: inc/iibs_defs.vh */
// constants for the i/o instruction bus sequencer
`ifndef IIBS_DEFS_VH
`define IIBS_DEFS_VH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define IIBS_OFF_CTRL 8'h00
`define IIBS_OFF_STAT 8'h04
`define IIBS_OFF_PC 8'h08
`define IIBS_OFF_ACCA 8'h0c
`define IIBS_OFF_IDXB 8'h10
// ---------------------------------------------
// register fields and reset values
// ---------------------------------------------
`define IIBS_CTRL_GO 0
`define IIBS_STAT_BUSY 0
`define IIBS_STAT_SKIP 1
`define IIBS_STAT_WAIT 2
`define IIBS_STAT_DONE 3
`define IIBS_RST_WORD 16'h0000
`define IIBS_RST_PC 15'h0000
// ---------------------------------------------
// first instruction word layout
// ---------------------------------------------
`define IIBS_W1_OP 15:12
`define IIBS_W1_IND 11
`define IIBS_W1_MAP 10
`define IIBS_W1_WAIT 9
`define IIBS_W1_UNIT 5:0
`define IIBS_OP_ACC_IN 4'h1
`define IIBS_OP_ACC_OUT 4'h2
`define IIBS_OP_MEM_IN 4'h3
`define IIBS_OP_MEM_OUT 4'h4
`define IIBS_OP_CMD 4'h5
`define IIBS_OP_TEST 4'h6
// ---------------------------------------------
// address word layout
// ---------------------------------------------
`define IIBS_W2_IDX 15
`define IIBS_W2_IND 14
`define IIBS_W2_ADDR 13:0
// ---------------------------------------------
// timing steps inside one machine cycle
// ---------------------------------------------
`define IIBS_T_FIRST 4'h0
`define IIBS_T_CAPT 4'h1
`define IIBS_T_STROBE 4'h8
`define IIBS_T_LAST 4'hf
`endif
